// [hw/dfsc_pkg.sv]
package dfsc_pkg;

   // Field positions of the data fault cause register.
   localparam int DFSC_TYPE_LO = 0;
   localparam int DFSC_TYPE_HI = 3;
   localparam int DFSC_DOM_LO = 4;
   localparam int DFSC_DOM_HI = 7;
   localparam int DFSC_ZERO_LO = 8;
   localparam int DFSC_ZERO_HI = 9;
   localparam int DFSC_EXT_BIT = 10;
   localparam int DFSC_WR_BIT = 11;
   localparam int DFSC_BUSERR_BIT = 12;
   localparam int DFSC_NFIELD = 13;

   // Writable bits: type, domain, extension, read/write, bus error kind.
   localparam logic [31:0] DFSC_WMASK = 32'h0000_1cff;
   localparam logic [31:0] DFSC_RESET = 32'h0000_0000;

   // Coprocessor register selector for this register.
   localparam logic [2:0] DFSC_OP1 = 3'h0;
   localparam logic [3:0] DFSC_CRN = 4'h5;
   localparam logic [3:0] DFSC_CRM = 4'h0;
   localparam logic [2:0] DFSC_OP2 = 3'h0;

   // Fault type codes, extension bit clear.
   localparam logic [3:0] DFSC_FT_NONE = 4'h0;
   localparam logic [3:0] DFSC_FT_ALIGN = 4'h1;
   localparam logic [3:0] DFSC_FT_DEBUG = 4'h2;
   localparam logic [3:0] DFSC_FT_CMAINT = 4'h4;
   localparam logic [3:0] DFSC_FT_TRANS_SEC = 4'h5;
   localparam logic [3:0] DFSC_FT_ACCESS_PG = 4'h6;
   localparam logic [3:0] DFSC_FT_TRANS_PG = 4'h7;
   localparam logic [3:0] DFSC_FT_EXT_PRECISE = 4'h8;
   localparam logic [3:0] DFSC_FT_DOM_SEC = 4'h9;
   localparam logic [3:0] DFSC_FT_NONE2 = 4'ha;
   localparam logic [3:0] DFSC_FT_DOM_PG = 4'hb;
   localparam logic [3:0] DFSC_FT_EXT_WALK1 = 4'hc;
   localparam logic [3:0] DFSC_FT_PERM_SEC = 4'hd;
   localparam logic [3:0] DFSC_FT_EXT_WALK2 = 4'he;
   localparam logic [3:0] DFSC_FT_PERM_PG = 4'hf;
   // Extension bit set: only the imprecise external abort.
   localparam logic [3:0] DFSC_FT_EXT_IMPRECISE = 4'h6;

   // Fault source kinds reported by the load/store and translation logic.
   typedef enum logic [3:0] {
      DFSC_SRC_ALIGN = 4'h0,
      DFSC_SRC_DEBUG = 4'h1,
      DFSC_SRC_CMAINT = 4'h2,
      DFSC_SRC_TRANS_SEC = 4'h3,
      DFSC_SRC_ACCESS_PG = 4'h4,
      DFSC_SRC_TRANS_PG = 4'h5,
      DFSC_SRC_EXT_PRECISE = 4'h6,
      DFSC_SRC_DOM_SEC = 4'h7,
      DFSC_SRC_DOM_PG = 4'h8,
      DFSC_SRC_EXT_WALK1 = 4'h9,
      DFSC_SRC_PERM_SEC = 4'ha,
      DFSC_SRC_EXT_WALK2 = 4'hb,
      DFSC_SRC_PERM_PG = 4'hc,
      DFSC_SRC_EXT_IMPRECISE = 4'hd
   } dfsc_src_t;

   // Access outcome states of the coprocessor port.
   typedef enum logic [1:0] {
      DFSC_ACC_IDLE = 2'b00,
      DFSC_ACC_READ = 2'b01,
      DFSC_ACC_WRITE = 2'b10,
      DFSC_ACC_UNDEF = 2'b11
   } dfsc_acc_t;

endpackage : dfsc_pkg

// [hw/dfsc_bank.sv]
`timescale 1ns/1ps
`default_nettype none

// Two-entry store, one word per world; read data come from a register.
module dfsc_bank #(
   parameter int WIDTH = 13
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic wr_en,
   input wire logic wr_sec,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic rd_sec,
   output logic [WIDTH-1:0] rd_data
);

   logic [WIDTH-1:0] word_r [2];

   // Both copies clear at reset.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         word_r[0] <= '0;
         word_r[1] <= '0;
      end else if (wr_en) begin
         word_r[wr_sec] <= wr_data;
      end
   end

   // Registered read; a write in the same cycle is seen one cycle later.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rd_data <= '0;
      end else begin
         rd_data <= word_r[rd_sec];
      end
   end

endmodule : dfsc_bank

`default_nettype wire

// [hw/dfsc_capture.sv]
// Contract
// - Hold a 32-bit read/write cause register, one copy per world, current world used.
// - Only privileged modes may access it; user mode access raises undefined exception.
// - Bits 9:8 read as zero and ignore writes.
// - External abort: bit 12 is one for slave error, zero for decode error.
// - Non-external aborts leave the bus error kind bit at zero.
// - Bit 11 records write as one, read as zero.
// - All defined fields reset to zero.
// - Bit 10 is the top bit of the fault type, extending bits 3:0.
// - Bits 7:4 take the accessed domain number on a data fault.
// - Alignment gives 0001, debug event 0010, cache maintenance 0100.
// - Section translation 0101, page access bit 0110, page translation 0111.
// - Precise external 1000, domain 1001/1011, permission 1101/1111.
// - External abort on first-level walk 1100, second-level walk 1110.
// - Codes 0000 and 1010 with extension clear mean no fault.
// - With extension set only 0110, imprecise external abort, is used.
// - Routed external abort entering monitor updates the secure copy.
`timescale 1ns/1ps
`default_nettype none

module dfsc_capture
   import dfsc_pkg::*;
#(
   parameter int NDOMAIN = 16
) (
   input wire logic clk_sys,
   input wire logic srst,
   // Coprocessor access port from the instruction pipeline.
   input wire logic cp_valid,
   input wire logic cp_write,
   input wire logic [2:0] cp_op1,
   input wire logic [3:0] cp_crn,
   input wire logic [3:0] cp_crm,
   input wire logic [2:0] cp_op2,
   input wire logic [31:0] cp_wdata,
   input wire logic cpu_privileged,
   input wire logic cpu_secure,
   output logic [31:0] cp_rdata,
   output logic cp_rvalid,
   output logic cp_undef,
   output logic cp_hit,
   // Fault report from the load/store and translation logic.
   input wire logic fault_valid,
   input wire logic [3:0] fault_src,
   input wire logic [3:0] fault_domain,
   input wire logic fault_write,
   input wire logic fault_slave_err,
   input wire logic external_abort_to_monitor,
   // Current world's register value, for the exception unit.
   output logic [31:0] cause_view
);

   // Elaboration check: the domain field is four bits wide, so only 16 domains fit.
   if (NDOMAIN != 16) begin : g_bad_ndomain
      $error("dfsc_capture: domain field holds exactly 16 domains");
   end

   // Builds the stored fields from a fault report; external-only bit kept zero otherwise.
   function automatic logic [DFSC_NFIELD-1:0] dfsc_encode(
      input logic [3:0] src,
      input logic [3:0] dom,
      input logic wr,
      input logic slave
   );
      logic [3:0] ft;
      logic ext;
      logic is_ext;
      logic [DFSC_NFIELD-1:0] w;
      ft = DFSC_FT_NONE;
      ext = 1'b0;
      is_ext = 1'b0;
      w = '0;
      case (src)
         DFSC_SRC_ALIGN: ft = DFSC_FT_ALIGN;
         DFSC_SRC_DEBUG: ft = DFSC_FT_DEBUG;
         DFSC_SRC_CMAINT: ft = DFSC_FT_CMAINT;
         DFSC_SRC_TRANS_SEC: ft = DFSC_FT_TRANS_SEC;
         DFSC_SRC_ACCESS_PG: ft = DFSC_FT_ACCESS_PG;
         DFSC_SRC_TRANS_PG: ft = DFSC_FT_TRANS_PG;
         DFSC_SRC_EXT_PRECISE: begin
            ft = DFSC_FT_EXT_PRECISE;
            is_ext = 1'b1;
         end
         DFSC_SRC_DOM_SEC: ft = DFSC_FT_DOM_SEC;
         DFSC_SRC_DOM_PG: ft = DFSC_FT_DOM_PG;
         DFSC_SRC_PERM_SEC: ft = DFSC_FT_PERM_SEC;
         DFSC_SRC_PERM_PG: ft = DFSC_FT_PERM_PG;
         DFSC_SRC_EXT_WALK1: begin
            ft = DFSC_FT_EXT_WALK1;
            is_ext = 1'b1;
         end
         DFSC_SRC_EXT_WALK2: begin
            ft = DFSC_FT_EXT_WALK2;
            is_ext = 1'b1;
         end
         DFSC_SRC_EXT_IMPRECISE: begin
            ft = DFSC_FT_EXT_IMPRECISE;
            ext = 1'b1;
            is_ext = 1'b1;
         end
         default: ft = DFSC_FT_NONE;
      endcase
      w[DFSC_TYPE_HI:DFSC_TYPE_LO] = ft;
      w[DFSC_DOM_HI:DFSC_DOM_LO] = dom;
      w[DFSC_EXT_BIT] = ext;
      w[DFSC_WR_BIT] = wr;
      w[DFSC_BUSERR_BIT] = is_ext & slave;
      return w;
   endfunction : dfsc_encode

   // Widens a stored word to 32 bits; bits 9:8 and 31:13 always read zero.
   function automatic logic [31:0] dfsc_widen(input logic [DFSC_NFIELD-1:0] w);
      logic [31:0] v;
      v = DFSC_RESET;
      v[DFSC_NFIELD-1:0] = w;
      return v & DFSC_WMASK;
   endfunction : dfsc_widen

   logic sel_hit;
   logic acc_ok;
   logic fault_sec;
   logic bank_wr_en;
   logic bank_wr_sec;
   logic [DFSC_NFIELD-1:0] bank_wdata;
   logic [DFSC_NFIELD-1:0] bank_rdata;
   logic [DFSC_NFIELD-1:0] sw_word;
   dfsc_acc_t acc_r;
   dfsc_acc_t acc_nxt;

   // Selector match for this register.
   assign sel_hit = cp_valid && cp_op1 == DFSC_OP1 && cp_crn == DFSC_CRN
                    && cp_crm == DFSC_CRM && cp_op2 == DFSC_OP2;
   assign acc_ok = sel_hit && cpu_privileged;

   // A routed external abort lands in the secure copy regardless of world.
   assign fault_sec = cpu_secure | external_abort_to_monitor;

   assign sw_word = cp_wdata[DFSC_NFIELD-1:0] & DFSC_WMASK[DFSC_NFIELD-1:0];

   // A fault report wins over a software write in the same cycle, so a real
   // fault is never lost; every field moves in one write.
   always_comb begin
      bank_wr_en = 1'b0;
      bank_wr_sec = cpu_secure;
      bank_wdata = sw_word;
      if (fault_valid) begin
         bank_wr_en = 1'b1;
         bank_wr_sec = fault_sec;
         bank_wdata = dfsc_encode(fault_src, fault_domain, fault_write, fault_slave_err);
      end else if (acc_ok && cp_write) begin
         bank_wr_en = 1'b1;
      end
   end

   dfsc_bank #(
      .WIDTH(DFSC_NFIELD)
   ) u_bank (
      .clk_sys(clk_sys),
      .srst(srst),
      .wr_en(bank_wr_en),
      .wr_sec(bank_wr_sec),
      .wr_data(bank_wdata),
      .rd_sec(cpu_secure),
      .rd_data(bank_rdata)
   );

   // Classify the access for the one-cycle answer.
   always_comb begin
      acc_nxt = DFSC_ACC_IDLE;
      if (sel_hit && !cpu_privileged) begin
         acc_nxt = DFSC_ACC_UNDEF;
      end else if (acc_ok && cp_write) begin
         acc_nxt = DFSC_ACC_WRITE;
      end else if (acc_ok) begin
         acc_nxt = DFSC_ACC_READ;
      end
   end

   // Access state, reset to idle.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         acc_r <= DFSC_ACC_IDLE;
      end else begin
         acc_r <= acc_nxt;
      end
   end

   // Answer strobes, one cycle after the request.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cp_rvalid <= 1'b0;
         cp_undef <= 1'b0;
         cp_hit <= 1'b0;
      end else begin
         cp_rvalid <= acc_nxt == DFSC_ACC_READ;
         cp_undef <= acc_nxt == DFSC_ACC_UNDEF;
         cp_hit <= acc_nxt == DFSC_ACC_READ || acc_nxt == DFSC_ACC_WRITE;
      end
   end

   // Read data. The bank answers one cycle after the request, so the data are
   // taken at the second edge; user-mode reads return zero.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cp_rdata <= DFSC_RESET;
      end else if (acc_r == DFSC_ACC_READ) begin
         cp_rdata <= dfsc_widen(bank_rdata);
      end else begin
         cp_rdata <= DFSC_RESET;
      end
   end

   // Live view of the current world's copy.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cause_view <= DFSC_RESET;
      end else begin
         cause_view <= dfsc_widen(bank_rdata);
      end
   end

endmodule : dfsc_capture

`default_nettype wire

// [dv/dfsc_capture_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// Watches the access and fault ports of the cause register.
module dfsc_capture_asserts
   import dfsc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic cp_valid,
   input wire logic cp_write,
   input wire logic [2:0] cp_op1,
   input wire logic [3:0] cp_crn,
   input wire logic [3:0] cp_crm,
   input wire logic [2:0] cp_op2,
   input wire logic cpu_privileged,
   input wire logic cpu_secure,
   input wire logic [31:0] cp_rdata,
   input wire logic cp_rvalid,
   input wire logic cp_undef,
   input wire logic cp_hit,
   input wire logic fault_valid,
   input wire logic [3:0] fault_src,
   input wire logic [3:0] fault_domain,
   input wire logic fault_write,
   input wire logic fault_slave_err,
   input wire logic external_abort_to_monitor
);
   logic sel;
   logic ext;
   // Selector match and external-abort kinds, shared by the properties below.
   assign sel = cp_valid && cp_op1 == DFSC_OP1 && cp_crn == DFSC_CRN && cp_crm == DFSC_CRM && cp_op2 == DFSC_OP2;
   assign ext = fault_src inside {4'h6, 4'h9, 4'hb, 4'hd};
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   // A fault, then a privileged read of the same world in the very next cycle.
   sequence fault_seen;
      fault_valid && !external_abort_to_monitor;
   endsequence
   sequence read_next;
      sel && !cp_write && cpu_privileged && !fault_valid && $stable(cpu_secure);
   endsequence
   undef_user_a: assert property (sel && !cpu_privileged |=> cp_undef && !cp_hit && !cp_rvalid)
      else $error("user access not refused");
   priv_hit_a: assert property (sel && cpu_privileged |=> cp_hit && !cp_undef)
      else $error("privileged access not taken");
   read_valid_a: assert property (sel && cpu_privileged && !cp_write |=> cp_rvalid)
      else $error("read not answered");
   zero_bits_a: assert property (cp_rdata[9:8] == 2'h0 && cp_rdata[31:13] == 19'h0)
      else $error("reserved bits not zero");
   idle_data_a: assert property (!cp_rvalid |=> cp_rdata == 32'h0)
      else $error("read data outside answer");
   fault_fields_a: assert property (fault_seen ##1 read_next |-> ##2
      cp_rdata[7:4] == $past(fault_domain, 3) && cp_rdata[11] == $past(fault_write, 3))
      else $error("domain or direction not captured");
   bus_kind_a: assert property (fault_seen ##1 read_next |-> ##2
      cp_rdata[12] == ($past(ext, 3) && $past(fault_slave_err, 3))) else $error("bus error kind wrong");
   ext_code_a: assert property (fault_seen ##1 read_next |-> ##2
      cp_rdata[10] == ($past(fault_src, 3) == 4'hd) && (!cp_rdata[10] || cp_rdata[3:0] == 4'h6))
      else $error("extension code wrong");
endmodule : dfsc_capture_asserts
`default_nettype wire

// [dv/dfsc_fault_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Load/store fault source: one abort report per call of raise.
module dfsc_fault_model (
   input wire logic clk_sys,
   output logic fault_valid,
   output logic [3:0] fault_src,
   output logic [3:0] fault_domain,
   output logic fault_write,
   output logic fault_slave_err,
   output logic external_abort_to_monitor
);
   initial begin
      fault_valid = 1'b0;
      {fault_src, fault_domain, fault_write, fault_slave_err, external_abort_to_monitor} = 11'h0;
   end
   // Fields stand only with the strobe; then they turn over and the monitor flag clears, so nothing stale looks valid.
   always @(posedge clk_sys) begin
      if (fault_valid) begin
         fault_valid <= 1'b0;
         {fault_src, fault_domain} <= ~{fault_src, fault_domain};
         {fault_write, fault_slave_err} <= ~{fault_write, fault_slave_err};
         external_abort_to_monitor <= 1'b0;
      end
   end
   // Launches the report on the next edge; the design samples it one edge later.
   task automatic raise(input logic [3:0] src, input logic [3:0] dom, input logic wr, input logic sl, input logic mon);
      @(posedge clk_sys);
      fault_valid <= 1'b1;
      {fault_src, fault_domain, fault_write, fault_slave_err, external_abort_to_monitor} <= {src, dom, wr, sl, mon};
   endtask : raise
endmodule : dfsc_fault_model
`default_nettype wire

// [dv/data_fault_status_capture_test.sv]
`timescale 1ns/1ps
`default_nettype none
module data_fault_status_capture_test;
   import dfsc_pkg::*;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic cp_valid = 1'b0, cp_write = 1'b0, cpu_privileged = 1'b0, cpu_secure = 1'b0;
   logic [2:0] cp_op1 = 3'h0, cp_op2 = 3'h0;
   logic [3:0] cp_crn = 4'h0, cp_crm = 4'h0, fault_src, fault_domain;
   logic [31:0] cp_wdata = 32'h0, cp_rdata, cause_view, rd;
   logic cp_rvalid, cp_undef, cp_hit, hit, undef, fault_valid, fault_write, fault_slave_err, external_abort_to_monitor;
   logic rv;
   int failures = 0, check_count = 0;
   logic [4:0] code_t [14] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0b, 5'h0c, 5'h0d, 5'h0e,
      5'h0f, 5'h16};
   // Free-running 50 MHz clock.
   always #10 clk_sys = ~clk_sys;
   dfsc_capture u_dfsc_capture (.clk_sys, .srst, .cp_valid, .cp_write, .cp_op1, .cp_crn, .cp_crm, .cp_op2,
      .cp_wdata, .cpu_privileged, .cpu_secure, .cp_rdata, .cp_rvalid, .cp_undef, .cp_hit, .fault_valid,
      .fault_src, .fault_domain, .fault_write, .fault_slave_err, .external_abort_to_monitor, .cause_view);
   dfsc_fault_model u_dfsc_fault_model (.clk_sys, .fault_valid, .fault_src, .fault_domain, .fault_write,
      .fault_slave_err, .external_abort_to_monitor);
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // One access; the answer strobes land one edge after it is taken, data one edge later.
   task automatic acc(input logic w, input logic [31:0] d, input logic p, input logic s, input logic [3:0] n);
      @(posedge clk_sys);
      {cp_valid, cp_write, cp_wdata, cpu_privileged, cpu_secure, cp_crn} <= {1'b1, w, d, p, s, n};
      @(posedge clk_sys);
      cp_valid <= 1'b0;
      cp_wdata <= ~d;
      #1 {hit, undef, rv} = {cp_hit, cp_undef, cp_rvalid};
      @(posedge clk_sys);
      #1 rd = cp_rdata;
   endtask : acc
   // Abort report in the nonsecure world, then a read of that world right behind it.
   task automatic fault_rd(input logic [3:0] s, input logic [3:0] d, input logic w, input logic l, input logic m);
      @(posedge clk_sys);
      cpu_secure <= 1'b0;
      u_dfsc_fault_model.raise(s, d, w, l, m);
      acc(1'b0, 32'h0, 1'b1, 1'b0, 4'h5);
   endtask : fault_rd
   task automatic t_reset;
      acc(0, 0, 1, 1, 4'h5);
      chk("secure reset", 0, rd);
      chk("read valid", 1, rv);
      acc(0, 0, 1, 0, 4'h5);
      chk("nonsecure reset", 0, rd);
   endtask : t_reset
   task automatic t_bank;
      acc(1, '1, 1, 1, 4'h5);
      chk("write hit", 1, hit);
      chk("write no read valid", 0, rv);
      acc(1, 32'h0000_0a5a, 1, 0, 4'h5);
      acc(0, 0, 1, 1, 4'h5);
      chk("secure read", 32'h0000_1cff, rd);
      acc(0, 0, 1, 0, 4'h5);
      chk("nonsecure read", 32'h0000_085a, rd);
   endtask : t_bank
   task automatic t_refuse;
      acc(1, 0, 0, 1, 4'h5);
      chk("user undef", 1, undef);
      acc(0, 0, 0, 1, 4'h5);
      chk("user data", 0, rd);
      acc(1, 0, 1, 1, 4'h2);
      chk("other hit", 0, hit);
      // A wrong second opcode must miss as well, so op2 is decoded besides crn.
      @(posedge clk_sys);
      cp_op2 <= 3'h1;
      acc(1, 0, 1, 1, 4'h5);
      chk("op2 hit", 0, hit);
      @(posedge clk_sys);
      cp_op2 <= 3'h0;
      acc(0, 0, 1, 1, 4'h5);
      chk("kept value", 32'h0000_1cff, rd);
   endtask : t_refuse
   // Every source kind, alternating direction and bus error kind.
   task automatic t_codes;
      logic [4:0] c;
      for (int i = 0; i < 15; i++) begin
         c = (i < 14) ? code_t[i] : 5'h00;
         fault_rd(i[3:0], 4'hf - i[3:0], i[0], i[1], 0);
         chk("cause type", {c[4], c[3:0]}, {rd[10], rd[3:0]});
         chk("cause domain", 4'hf - i[3:0], rd[7:4]);
         chk("cause direction", i[0], rd[11]);
         chk("cause bus kind", i[1] && i inside {6, 9, 11, 13}, rd[12]);
         chk("cause zero bits", 0, {rd[31:13], rd[9:8]});
      end
   endtask : t_codes
   task automatic t_monitor;
      fault_rd(4'h6, 4'h2, 1, 1, 1);
      chk("nonsecure kept", 32'h0000_0010, rd);
      acc(0, 0, 1, 1, 4'h5);
      chk("secure routed", 32'h0000_1828, rd);
      chk("secure view", 32'h0000_1828, cause_view);
   endtask : t_monitor
   // Reset in mid-run, with both copies holding values, must clear them again.
   task automatic t_midreset;
      @(posedge clk_sys);
      srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      acc(0, 0, 1, 1, 4'h5);
      chk("secure cleared", 0, rd);
      acc(0, 0, 1, 0, 4'h5);
      chk("nonsecure cleared", 0, rd);
      chk("view cleared", 0, cause_view);
   endtask : t_midreset
   task automatic give_verdict;
      $display("failures %0d checks %0d", failures, check_count);
      if (failures == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   // Reset for four cycles, then the scenarios in turn.
   initial begin
      repeat (4) @(posedge clk_sys);
      srst <= 1'b0;
      t_reset();
      t_bank();
      t_refuse();
      t_codes();
      t_monitor();
      t_midreset();
      give_verdict();
   end
endmodule : data_fault_status_capture_test
bind dfsc_capture dfsc_capture_asserts u_dfsc_capture_asserts (.clk_sys, .srst, .cp_valid, .cp_write, .cp_op1,
   .cp_crn, .cp_crm, .cp_op2, .cpu_privileged, .cpu_secure, .cp_rdata, .cp_rvalid, .cp_undef, .cp_hit, .fault_valid,
   .fault_src, .fault_domain, .fault_write, .fault_slave_err, .external_abort_to_monitor);
`default_nettype wire
